// ### rtl/bcag_top.sv
`timescale 1ns/1ps
module bcag_top
  import bcag_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic resetn,
  input wire bcag_cmd_type cmd,
  input wire logic cmd_valid,
  output logic cmd_ready,
  output bcag_acc_type acc,
  output logic acc_valid,
  input wire logic acc_ready,
  output logic done,
  output logic rejected
);
  localparam int AW = $bits(bcag_acc_type);

  typedef enum {ST_IDLE, ST_CHECK, ST_WALK, ST_DRAIN} bcag_state_type;

  function automatic logic [ADDR_W-1:0] pix_addr(
    input logic [ADDR_W-1:0] base,
    input logic signed [COORD_W-1:0] x,
    input logic signed [COORD_W-1:0] y,
    input logic [PITCH_W-1:0] pitch,
    input logic tiled,
    input logic [BPP_W-1:0] bpp
  );
    logic [ADDR_W-1:0] pb;
    logic [ADDR_W-1:0] yo;
    logic [ADDR_W-1:0] xo;
    // linear pitch is bytes, tiled pitch is dwords
    pb = tiled ? (ADDR_W'(pitch) << 2) : ADDR_W'(pitch);
    // widen first so large coordinates do not wrap at coordinate width
    yo = ADDR_W'(y) * pb;
    xo = ADDR_W'(x) * ADDR_W'(bpp);
    return base + yo + xo;
  endfunction : pix_addr

  function automatic logic signed [COORD_W-1:0] smax(
    input logic signed [COORD_W-1:0] a,
    input logic signed [COORD_W-1:0] b
  );
    return (a > b) ? a : b;
  endfunction : smax

  function automatic logic signed [COORD_W-1:0] smin(
    input logic signed [COORD_W-1:0] a,
    input logic signed [COORD_W-1:0] b
  );
    return (a < b) ? a : b;
  endfunction : smin

  bcag_state_type state_q;
  logic signed [COORD_W-1:0] clip_left_q;
  logic signed [COORD_W-1:0] clip_top_q;
  logic signed [COORD_W-1:0] clip_right_q;
  logic signed [COORD_W-1:0] clip_bottom_q;
  bcag_cmd_type cmd_q;
  logic signed [COORD_W-1:0] x_lo_q;
  logic signed [COORD_W-1:0] x_hi_q;
  logic signed [COORD_W-1:0] y_lo_q;
  logic signed [COORD_W-1:0] y_hi_q;
  logic signed [COORD_W-1:0] src_off_x_q;
  logic signed [COORD_W-1:0] src_off_y_q;
  logic signed [COORD_W-1:0] cur_x_q;
  logic signed [COORD_W-1:0] cur_y_q;
  logic x_back_q;
  logic y_back_q;
  logic cmd_ready_q;
  logic done_q;
  logic rejected_q;

  logic signed [COORD_W-1:0] adj_x1;
  logic signed [COORD_W-1:0] adj_y1;
  logic signed [COORD_W-1:0] dst_start_x;
  logic signed [COORD_W-1:0] dst_start_y;
  logic signed [COORD_W-1:0] dst_end_x;
  logic signed [COORD_W-1:0] dst_end_y;
  logic signed [COORD_W-1:0] top_discard_lines;
  logic signed [COORD_W-1:0] left_discard_pixels;
  logic degenerate;
  logic has_src;
  logic is_draw;

  bcag_acc_type push_acc;
  logic push_valid;
  logic push_ready;
  logic fifo_empty_n;
  logic last_x;
  logic last_y;

  assign cmd_ready = cmd_ready_q;
  assign done = done_q;
  assign rejected = rejected_q;
  assign is_draw = (cmd.opcode == OPC_SRC_COPY) || (cmd.opcode == OPC_FILL);
  assign has_src = cmd.opcode == OPC_SRC_COPY;

  assign adj_x1 = (has_src && cmd.sx1 < 0) ? cmd.x1 - cmd.sx1 : cmd.x1;
  assign adj_y1 = (has_src && cmd.sy1 < 0) ? cmd.y1 - cmd.sy1 : cmd.y1;

  assign dst_start_x = cmd.clip_en ? smax(adj_x1, clip_left_q) : adj_x1;
  assign dst_start_y = cmd.clip_en ? smax(adj_y1, clip_top_q) : adj_y1;
  assign dst_end_x = cmd.clip_en ? smin(cmd.x2, clip_right_q) : cmd.x2;
  assign dst_end_y = cmd.clip_en ? smin(cmd.y2, clip_bottom_q) : cmd.y2;

  assign top_discard_lines = dst_start_y - cmd.y1;
  assign left_discard_pixels = dst_start_x - cmd.x1;

  assign degenerate = (dst_end_x <= dst_start_x) || (dst_end_y <= dst_start_y);

  assign last_x = x_back_q ? (cur_x_q == x_lo_q) : (cur_x_q == x_hi_q - 1);
  assign last_y = y_back_q ? (cur_y_q == y_lo_q) : (cur_y_q == y_hi_q - 1);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      clip_left_q <= COORD_RST;
      clip_top_q <= COORD_RST;
      clip_right_q <= COORD_RST;
      clip_bottom_q <= COORD_RST;
    end else if (state_q == ST_IDLE && cmd_valid && cmd_ready_q
                 && cmd.opcode == OPC_SETUP_CLIP) begin
      clip_left_q <= cmd.x1;
      clip_top_q <= cmd.y1;
      clip_right_q <= cmd.x2;
      clip_bottom_q <= cmd.y2;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      cmd_q <= '0;
      x_lo_q <= COORD_RST;
      x_hi_q <= COORD_RST;
      y_lo_q <= COORD_RST;
      y_hi_q <= COORD_RST;
      src_off_x_q <= COORD_RST;
      src_off_y_q <= COORD_RST;
      cur_x_q <= COORD_RST;
      cur_y_q <= COORD_RST;
      x_back_q <= 1'b0;
      y_back_q <= 1'b0;
      cmd_ready_q <= 1'b0;
      done_q <= 1'b0;
      rejected_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      rejected_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          cmd_ready_q <= 1'b1;
          if (cmd_valid && cmd_ready_q) begin
            cmd_ready_q <= 1'b0;
            cmd_q <= cmd;
            if (!is_draw) begin
              done_q <= 1'b1;
              state_q <= ST_DRAIN;
            end else if (degenerate) begin
              done_q <= 1'b1;
              rejected_q <= 1'b1;
              state_q <= ST_DRAIN;
            end else begin
              x_lo_q <= dst_start_x;
              x_hi_q <= dst_end_x;
              y_lo_q <= dst_start_y;
              y_hi_q <= dst_end_y;
              // source coordinate of pixel = dest coordinate + offset
              src_off_x_q <= cmd.sx1 - cmd.x1;
              src_off_y_q <= cmd.sy1 - cmd.y1;
              state_q <= ST_CHECK;
            end
          end
        end
        ST_CHECK: begin
          // same base and source left of dest: walk right to left
          x_back_q <= has_src_q() && cmd_q.sx1 < cmd_q.x1;
          y_back_q <= has_src_q() && cmd_q.sy1 < cmd_q.y1;
          cur_x_q <= (has_src_q() && cmd_q.sx1 < cmd_q.x1)
                     ? COORD_W'(x_hi_q - 1) : x_lo_q;
          cur_y_q <= (has_src_q() && cmd_q.sy1 < cmd_q.y1)
                     ? COORD_W'(y_hi_q - 1) : y_lo_q;
          state_q <= ST_WALK;
        end
        ST_WALK: begin
          if (push_ready) begin
            if (!last_x) begin
              cur_x_q <= x_back_q ? COORD_W'(cur_x_q - 1)
                                  : COORD_W'(cur_x_q + 1);
            end else begin
              cur_x_q <= x_back_q ? COORD_W'(x_hi_q - 1) : x_lo_q;
              if (last_y) begin
                done_q <= 1'b1;
                state_q <= ST_DRAIN;
              end else begin
                cur_y_q <= y_back_q ? COORD_W'(cur_y_q - 1)
                                    : COORD_W'(cur_y_q + 1);
              end
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  function automatic logic has_src_q();
    return (cmd_q.opcode == OPC_SRC_COPY)
           && (cmd_q.src_base == cmd_q.dst_base);
  endfunction : has_src_q

  assign push_valid = state_q == ST_WALK;
  always_comb begin
    push_acc.has_src = cmd_q.opcode == OPC_SRC_COPY;
    push_acc.dst_addr = pix_addr(cmd_q.dst_base, cur_x_q, cur_y_q,
                                 cmd_q.dst_pitch, cmd_q.dst_tiled,
                                 cmd_q.bytes_pp);
    push_acc.src_addr = pix_addr(cmd_q.src_base, cur_x_q + src_off_x_q,
                                 cur_y_q + src_off_y_q,
                                 cmd_q.src_pitch, cmd_q.src_tiled,
                                 cmd_q.bytes_pp);
  end

  // fifo decouples walker from memory stalls
  bcag_fifo #(
    .WIDTH(AW),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_data(push_acc),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .out_data(acc),
    .out_valid(fifo_empty_n),
    .out_ready(acc_ready)
  );
  assign acc_valid = fifo_empty_n;
endmodule : bcag_top

// ### rtl/bcag_pkg.sv
package bcag_pkg;
  localparam int COORD_W = 16;
  localparam int PITCH_W = 18;
  localparam int ADDR_W = 48;
  localparam int BPP_W = 3;
  localparam int FIFO_DEPTH = 32;

  // instruction target field codes
  localparam logic [2:0] OPC_SRC_COPY = 3'h0;
  localparam logic [2:0] OPC_FILL = 3'h1;
  localparam logic [2:0] OPC_SETUP_CLIP = 3'h2;
  localparam logic [2:0] OPC_SETUP_BASE = 3'h3;

  localparam logic [COORD_W-1:0] COORD_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 48'h000000000000;

  typedef struct packed {
    logic [2:0] opcode;
    logic clip_en;
    logic src_tiled;
    logic dst_tiled;
    logic [BPP_W-1:0] bytes_pp;
    logic signed [COORD_W-1:0] x1;
    logic signed [COORD_W-1:0] y1;
    logic signed [COORD_W-1:0] x2;
    logic signed [COORD_W-1:0] y2;
    logic signed [COORD_W-1:0] sx1;
    logic signed [COORD_W-1:0] sy1;
    logic [PITCH_W-1:0] src_pitch;
    logic [PITCH_W-1:0] dst_pitch;
    logic [ADDR_W-1:0] src_base;
    logic [ADDR_W-1:0] dst_base;
  } bcag_cmd_type;

  typedef struct packed {
    logic [ADDR_W-1:0] src_addr;
    logic [ADDR_W-1:0] dst_addr;
    logic has_src;
  } bcag_acc_type;
endpackage : bcag_pkg

// ### rtl/bcag_fifo.sv
`timescale 1ns/1ps
module bcag_fifo #(
  parameter int WIDTH = 97,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rd_q];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : bcag_fifo

// ### sim/bcag_assertions.sv
`timescale 1ns/1ps
module bcag_checker
  import bcag_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire bcag_cmd_type cmd,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire bcag_acc_type acc,
  input wire logic acc_valid,
  input wire logic acc_ready,
  input wire logic done,
  input wire logic rejected
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_done_one_pulse: assert property (done |=> !done)
    else $error("done too long");
  a_reject_with_done: assert property (rejected |-> done)
    else $error("reject without done");
  a_take_drops_ready: assert property (cmd_valid && cmd_ready
      |=> !cmd_ready)
    else $error("ready after take");
  a_acc_held: assert property (acc_valid && !acc_ready
      |=> acc_valid && $stable(acc))
    else $error("acc changed");
  a_reject_no_access: assert property (rejected && !acc_valid |=> !acc_valid [*2])
    else $error("access after reject");
  a_ready_back: assert property (done |-> ##[1:2] cmd_ready)
    else $error("ready late");
  a_done_not_ready: assert property (done |-> !cmd_ready)
    else $error("ready with done");
  a_answer_bound: assert property (cmd_valid && cmd_ready
      && !acc_valid |-> ##[1:3] (acc_valid || done))
    else $error("no answer");
endmodule : bcag_checker
bind bcag_top bcag_checker u_chk (.clk(clk), .resetn(resetn), .cmd(cmd),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .acc(acc),
  .acc_valid(acc_valid), .acc_ready(acc_ready), .done(done),
  .rejected(rejected));

// ### sim/bcag_sink.sv
`timescale 1ns/1ps
module bcag_sink
  import bcag_pkg::*;
(
  input wire logic clk,
  input wire bcag_acc_type acc,
  input wire logic acc_valid,
  input wire logic stall,
  output logic acc_ready
);
  bcag_acc_type got[$];
  // stall lets the bench back up the fifo
  assign acc_ready = !stall;
  always @(posedge clk) begin
    if (acc_valid && acc_ready) begin
      got.push_back(acc);
    end
  end
endmodule : bcag_sink

// ### sim/blit_clip_address_gen_test.sv
`timescale 1ns/1ps
module blit_clip_address_gen_test;
  import bcag_pkg::*;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  bcag_cmd_type cmd = '0;
  logic cmd_valid = 1'h0;
  logic stall = 1'h0;
  logic cmd_ready, acc_valid, acc_ready, done, rejected;
  bcag_acc_type acc;
  int mismatches = 0;
  int checks_done = 0;
  bcag_acc_type exp_q[$];
  bcag_cmd_type c;
  bcag_top #(.DEPTH(FIFO_DEPTH)) uut (.clk(clk), .resetn(resetn), .cmd(cmd),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .acc(acc),
    .acc_valid(acc_valid), .acc_ready(acc_ready), .done(done),
    .rejected(rejected));
  bcag_sink sink (.clk(clk), .acc(acc), .acc_valid(acc_valid),
    .stall(stall), .acc_ready(acc_ready));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic cmp_acc(input bcag_acc_type g, input bcag_acc_type e);
    // source address is a don't-care for fills
    if (e.has_src === 1'h0) g.src_addr = e.src_addr;
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %0t %h %h", $time, g, e);
    end
  endtask : cmp_acc
  task automatic cmp_bit(input logic g, input logic e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %0t %h %h", $time, g, e);
    end
  endtask : cmp_bit
  function automatic bcag_cmd_type mk(input logic [2:0] op, input logic ce,
      input logic dt, input int x1, y1, x2, y2, sx, sy, sp, dp,
      input logic [47:0] sb, db);
    mk = '0;
    mk.opcode = op;
    mk.clip_en = ce;
    mk.dst_tiled = dt;
    mk.bytes_pp = 3'h4;
    {mk.x1, mk.y1, mk.x2, mk.y2} = {16'(x1), 16'(y1), 16'(x2), 16'(y2)};
    {mk.sx1, mk.sy1} = {16'(sx), 16'(sy)};
    {mk.src_pitch, mk.dst_pitch} = {18'(sp), 18'(dp)};
    {mk.src_base, mk.dst_base} = {sb, db};
  endfunction : mk
  task automatic exp_rect(input int xa, xb, ya, yb, input logic xr, yr);
    int x, y, dp, sp;
    bcag_acc_type e;
    dp = c.dst_tiled ? 4 * int'(c.dst_pitch) : int'(c.dst_pitch);
    sp = c.src_tiled ? 4 * int'(c.src_pitch) : int'(c.src_pitch);
    for (int r = 0; r < yb - ya; r++) begin
      for (int p = 0; p < xb - xa; p++) begin
        y = yr ? yb - 1 - r : ya + r;
        x = xr ? xb - 1 - p : xa + p;
        e.dst_addr = c.dst_base + 48'(y * dp + x * 4);
        e.src_addr = c.src_base + 48'((y + c.sy1 - c.y1) * sp
          + (x + c.sx1 - c.x1) * 4);
        e.has_src = c.opcode == OPC_SRC_COPY;
        exp_q.push_back(e);
      end
    end
  endtask : exp_rect
  task automatic send;
    int n = 0;
    @(negedge clk);
    cmd = c;
    cmd_valid = 1'h1;
    while (cmd_ready !== 1'h1 && n++ < 200) @(negedge clk);
    @(negedge clk);
    cmd_valid = 1'h0;
  endtask : send
  task automatic finish(input logic rej);
    int n = 0;
    while (done !== 1'h1 && n++ < 400) @(negedge clk);
    cmp_bit(rejected, rej);
    n = 0;
    while (acc_valid !== 1'h0 && n++ < 200) @(negedge clk);
    @(negedge clk);
    cmp_bit(sink.got.size() == exp_q.size(), 1'h1);
    foreach (exp_q[i]) if (i < sink.got.size()) cmp_acc(sink.got[i], exp_q[i]);
    sink.got.delete();
    exp_q.delete();
  endtask : finish
  task automatic run(input logic rej);
    send();
    finish(rej);
  endtask : run
  task automatic t_fill_stalled;
    // x-tiled pitch 128 dwords is 512 bytes
    c = mk(OPC_FILL, 0, 1, 0, 0, 40, 2, 0, 0, 0, 128, 0, 48'h20000);
    exp_rect(0, 40, 0, 2, 0, 0);
    stall = 1'h1;
    send();
    repeat (60) @(negedge clk);
    cmp_bit(cmd_ready, 1'h0);
    cmp_bit(acc_valid, 1'h1);
    stall = 1'h0;
    finish(1'h0);
  endtask : t_fill_stalled
  initial begin
    #100us;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    repeat (20) @(negedge clk);
    cmp_bit(cmd_ready | acc_valid | done, 1'h0);
    resetn = 1'h1;
    // one clip set, loaded once and shared by both clipped draws
    c = mk(OPC_SETUP_CLIP, 0, 0, 2, 1, 4, 3, 0, 0, 0, 0, 0, 0);
    run(1'h0);
    c = mk(OPC_SRC_COPY, 1, 0, 1, 0, 5, 4, 10, 20, 32, 64, 48'h1000, 48'h8000);
    exp_rect(2, 4, 1, 3, 0, 0);
    run(1'h0);
    c = mk(OPC_SRC_COPY, 1, 0, 5, 5, 8, 8, 0, 0, 32, 64, 48'h1000, 48'h8000);
    run(1'h1);
    c = mk(OPC_SRC_COPY, 0, 0, 0, 0, 3, 2, -2, -1, 32, 64, 48'h1000, 48'h8000);
    exp_rect(2, 3, 1, 2, 0, 0);
    run(1'h0);
    c = mk(OPC_SRC_COPY, 0, 0, 0, 0, 2, 5, -2, 0, 32, 64, 48'h1000, 48'h8000);
    run(1'h1);
    c = mk(OPC_SRC_COPY, 0, 0, 4, 4, 6, 6, 3, 3, 64, 64, 48'h4000, 48'h4000);
    exp_rect(4, 6, 4, 6, 1, 1);
    run(1'h0);
    // y-tiled pitch 128 bytes is 32 dwords on both sides
    c = mk(OPC_SRC_COPY, 0, 1, 0, 0, 2, 2, 1, 1, 32, 32, 48'h1000, 48'h8000);
    c.src_tiled = 1'h1;
    exp_rect(0, 2, 0, 2, 0, 0);
    run(1'h0);
    t_fill_stalled();
    c = mk(OPC_SETUP_BASE, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0);
    run(1'h0);
    tally_and_finish();
  end
endmodule : blit_clip_address_gen_test
